// ### verilog/reload_timer_unit.sv
// reload timer unit: fixed pair, wide timer, selectable pair, AXI4-Lite slave

module reload_timer_unit
	import reload_timer_pkg::*;
(
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// external event input, asynchronous
	input  wire logic              wide_timer_input_pin,
	// write address channel
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// write data channel
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// write response channel
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// read address channel
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// read data channel
	output logic [DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);

	// ==========================================================
	// declarations
	logic [ADDR_W-1:0] aw_addr_reg;     // held write address
	logic [DATA_W-1:0] w_data_reg;      // held write data
	logic [3:0]        w_strb_reg;      // held byte enables
	logic              do_write;        // both halves present
	logic              wr_byte;         // low lane enabled
	logic              wr_mapped;       // write hits a register
	logic              rd_take;         // read address handshake
	logic [DATA_W-1:0] rd_value;        // read mux result
	logic              rd_mapped;       // read hits a register
	logic [7:0]        wbyte;           // written byte

	logic [DIV_W-1:0]  div_reg;         // free oscillator divider
	logic              tick16;          // oscillator over sixteen
	logic              sel_tick;        // selectable pair source

	logic              fixed_uf;        // fixed pair underflow pulse
	logic              sel_uf;          // selectable pair underflow pulse
	logic [7:0]        fixed_pre_cnt;
	logic [7:0]        fixed_tmr_cnt;
	logic [7:0]        sel_pre_cnt;
	logic [7:0]        sel_tmr_cnt;
	logic [SRC_W-1:0]  src_reg;         // selectable count source

	logic [CTRL_W-1:0] ctrl_reg;        // wide timer mode, edge, stop
	wide_mode_t        mode;
	logic              edge_rising;     // edge select bit
	logic              stopped;         // count stop bit
	logic [15:0]       wide_cnt_reg;    // live wide counter
	logic [15:0]       wide_latch_reg;  // wide reload value
	logic [7:0]        low_buf_reg;     // buffered low byte
	logic [15:0]       capture_reg;     // measured value
	logic              held_reg;        // capture awaiting read
	logic [7:0]        low_snap_reg;    // low byte frozen by high read
	logic [15:0]       wide_view;       // value shown to reads
	logic              measuring;       // either measurement mode
	logic              wide_tick;       // wide counter count pulse
	logic              wide_uf;         // wide counter passes zero
	logic              meas_edge;       // accepted measurement edge
	logic              pin_flag_set;    // pin request event
	logic              wide_uf_reg;     // registered underflow
	logic              wr_wide_high;
	logic              rd_wide_low;

	logic [2:0]        pin_sync_reg;    // two sync stages plus history
	logic              pin_rise;
	logic              pin_fall;
	logic              pin_sel_edge;

	logic [FLAG_W-1:0] flags_reg;       // sticky request flags
	logic [FLAG_W-1:0] flag_set;
	logic [FLAG_W-1:0] flag_clr;

	// ==========================================================
	// write path: address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			aw_addr_reg   <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			aw_addr_reg   <= {s_axi_awaddr[ADDR_W-1:2], 2'b00}; // byte lane bits ignored
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end

	// write data holding
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b1;
			w_data_reg   <= '0;
			w_strb_reg   <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			w_data_reg   <= s_axi_wdata;
			w_strb_reg   <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end

	// one write is performed once both halves are held
	assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wr_byte  = do_write && w_strb_reg[0];
	assign wbyte    = w_data_reg[7:0];

	// write decode; unmapped answers with an error
	always_comb begin
		unique case ({aw_addr_reg[ADDR_W-1:2], 2'b00})
			OFS_FIXED_PRE, OFS_FIXED_TMR, OFS_WIDE_LOW, OFS_WIDE_HIGH,
			OFS_WIDE_MODE, OFS_SEL_PRE, OFS_SEL_TMR, OFS_SEL_SRC,
			OFS_FLAGS: wr_mapped = 1'b1;
			default:   wr_mapped = 1'b0;
		endcase
	end

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// oscillator divider and count sources
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 1'b1;
		end
	end

	assign tick16 = &div_reg;

	// source mux; a limitation: faster sources share the same divider phase
	always_comb begin
		unique case (src_reg)
			SRC_DIV16: sel_tick = &div_reg;
			SRC_DIV8:  sel_tick = &div_reg[2:0];
			SRC_DIV2:  sel_tick = div_reg[0];
			SRC_DIV1:  sel_tick = 1'b1;
		endcase
	end

	// ==========================================================
	// the two eight-bit pairs; neither has a stop input
	timer_pair #(.WIDTH(8)) u_fixed (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.tick       (tick16),
		.pre_load   (wr_byte && aw_addr_reg == OFS_FIXED_PRE),
		.tmr_load   (wr_byte && aw_addr_reg == OFS_FIXED_TMR),
		.load_value (wbyte),
		.pre_count  (fixed_pre_cnt),
		.tmr_count  (fixed_tmr_cnt),
		.underflow  (fixed_uf)
	);

	timer_pair #(.WIDTH(8)) u_select (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.tick       (sel_tick),
		.pre_load   (wr_byte && aw_addr_reg == OFS_SEL_PRE),
		.tmr_load   (wr_byte && aw_addr_reg == OFS_SEL_TMR),
		.load_value (wbyte),
		.pre_count  (sel_pre_cnt),
		.tmr_count  (sel_tmr_cnt),
		.underflow  (sel_uf)
	);

	// source select register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_reg <= SRC_DIV16;
		end else if (wr_byte && aw_addr_reg == OFS_SEL_SRC) begin
			src_reg <= wbyte[SRC_W-1:0];
		end
	end

	// ==========================================================
	// pin synchroniser; only the second stage and history are looked at
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_sync_reg <= '0;
		end else begin
			pin_sync_reg <= {pin_sync_reg[1:0], wide_timer_input_pin};
		end
	end

	assign pin_rise     = pin_sync_reg[1] && !pin_sync_reg[2];
	assign pin_fall     = !pin_sync_reg[1] && pin_sync_reg[2];
	assign pin_sel_edge = edge_rising ? pin_rise : pin_fall;

	// ==========================================================
	// wide timer control
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= '0;
		end else if (wr_byte && aw_addr_reg == OFS_WIDE_MODE) begin
			ctrl_reg <= wbyte[CTRL_W-1:0];
		end
	end

	assign mode        = wide_mode_t'(ctrl_reg[MODE_LSB +: 2]);
	assign edge_rising = ctrl_reg[EDGE_BIT];
	assign stopped     = ctrl_reg[STOP_BIT];
	assign measuring   = (mode == WIDE_PERIOD) || (mode == WIDE_PULSE_HL);

	// count pulse per mode; stop gates all of them
	always_comb begin
		unique case (mode)
			WIDE_EVENT: wide_tick = pin_sel_edge;
			WIDE_TIMER, WIDE_PERIOD, WIDE_PULSE_HL: begin
				wide_tick = tick16;
			end
		endcase
		if (stopped) begin
			wide_tick = 1'b0;
		end
	end

	// accepted edge: both polarities in pulse mode regardless of edge bit
	assign meas_edge = !stopped && ((mode == WIDE_PULSE_HL) ? (pin_rise || pin_fall)
		: ((mode == WIDE_PERIOD) && pin_sel_edge));
	assign pin_flag_set = (mode == WIDE_PULSE_HL) ? (pin_rise || pin_fall)
		: pin_sel_edge;
	assign wide_uf      = wide_tick && (wide_cnt_reg == '0);
	assign wr_wide_high = wr_byte && aw_addr_reg == OFS_WIDE_HIGH;

	// low byte is only buffered; high write commits both halves
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			low_buf_reg <= BYTE_RESET;
		end else if (wr_byte && aw_addr_reg == OFS_WIDE_LOW) begin
			low_buf_reg <= wbyte;
		end
	end

	// latch and counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wide_latch_reg <= WIDE_RESET;
			wide_cnt_reg   <= WIDE_RESET;
		end else if (wr_wide_high) begin
			wide_latch_reg <= {wbyte, low_buf_reg};
			wide_cnt_reg   <= {wbyte, low_buf_reg};
		end else if (wide_uf || meas_edge) begin
			wide_cnt_reg   <= wide_latch_reg;
		end else if (wide_tick) begin
			wide_cnt_reg   <= wide_cnt_reg - 1'b1;
		end
	end

	// capture is frozen until the low byte read finishes the pair
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			capture_reg <= '0;
			held_reg    <= 1'b0;
		end else if (meas_edge && (!held_reg || rd_wide_low)) begin
			capture_reg <= wide_cnt_reg;
			held_reg    <= 1'b1;
		end else if (rd_wide_low) begin
			held_reg    <= 1'b0;
		end
	end

	assign wide_view = measuring ? capture_reg : wide_cnt_reg;

	// delay the wide underflow so the three underflow flag sets line up
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wide_uf_reg <= 1'b0;
		end else begin
			wide_uf_reg <= wide_uf;
		end
	end

	// ==========================================================
	// request flags: a new event beats a clear in the same cycle
	assign flag_set[FLAG_FIXED] = fixed_uf;
	assign flag_set[FLAG_WIDE]  = wide_uf_reg;
	assign flag_set[FLAG_PIN]   = pin_flag_set;
	assign flag_set[FLAG_SEL]   = sel_uf;
	assign flag_clr = (wr_byte && aw_addr_reg == OFS_FLAGS) ? wbyte[FLAG_W-1:0] : '0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_reg <= '0;
		end else begin
			for (int i = 0; i < FLAG_W; i++) begin
				if (flag_set[i]) begin
					flags_reg[i] <= 1'b1;
				end else if (flag_clr[i]) begin
					flags_reg[i] <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// read path
	assign rd_take     = s_axi_arvalid && s_axi_arready;
	assign rd_wide_low = rd_take && ({s_axi_araddr[ADDR_W-1:2], 2'b00} == OFS_WIDE_LOW);

	// read mux; unmapped reads return zero with an error
	always_comb begin
		rd_value  = '0;
		rd_mapped = 1'b1;
		unique case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
			OFS_FIXED_PRE: rd_value[7:0]        = fixed_pre_cnt;
			OFS_FIXED_TMR: rd_value[7:0]        = fixed_tmr_cnt;
			OFS_WIDE_LOW:  rd_value[7:0]        = low_snap_reg;
			OFS_WIDE_HIGH: rd_value[7:0]        = wide_view[15:8];
			OFS_WIDE_MODE: rd_value[CTRL_W-1:0] = ctrl_reg;
			OFS_SEL_PRE:   rd_value[7:0]        = sel_pre_cnt;
			OFS_SEL_TMR:   rd_value[7:0]        = sel_tmr_cnt;
			OFS_SEL_SRC:   rd_value[SRC_W-1:0]  = src_reg;
			OFS_FLAGS:     rd_value[FLAG_W-1:0] = flags_reg;
			default:       rd_mapped            = 1'b0;
		endcase
	end

	// high byte read freezes the low byte so the pair stays coherent
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			low_snap_reg <= '0;
		end else if (rd_take && ({s_axi_araddr[ADDR_W-1:2], 2'b00} == OFS_WIDE_HIGH)) begin
			low_snap_reg <= wide_view[7:0];
		end
	end

	// read handshake, one outstanding
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (rd_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_value;
			s_axi_rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end

endmodule // reload_timer_unit

// ### verilog/reload_timer_pkg.sv
// shared constants and types for the reload timer unit
package reload_timer_pkg;

	// ==========================================================
	// register bus
	localparam int          ADDR_W          = 8;     // byte address bits decoded
	localparam int          DATA_W          = 32;    // bus data width
	localparam logic [1:0]  RESP_OKAY       = 2'h0;  // normal answer
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;  // unmapped offset

	// ==========================================================
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_FIXED_PRE  = 8'h00; // fixed_prescaler
	localparam logic [ADDR_W-1:0] OFS_FIXED_TMR  = 8'h04; // fixed_timer
	localparam logic [ADDR_W-1:0] OFS_WIDE_LOW   = 8'h08; // wide_timer_low
	localparam logic [ADDR_W-1:0] OFS_WIDE_HIGH  = 8'h0C; // wide_timer_high
	localparam logic [ADDR_W-1:0] OFS_WIDE_MODE  = 8'h10; // wide timer control
	localparam logic [ADDR_W-1:0] OFS_SEL_PRE    = 8'h14; // selectable_prescaler
	localparam logic [ADDR_W-1:0] OFS_SEL_TMR    = 8'h18; // selectable timer
	localparam logic [ADDR_W-1:0] OFS_SEL_SRC    = 8'h1C; // count source select
	localparam logic [ADDR_W-1:0] OFS_FLAGS      = 8'h20; // request flags, w1c

	// ==========================================================
	// wide timer control fields
	localparam int MODE_LSB  = 0;   // two-bit mode field
	localparam int EDGE_BIT  = 2;   // 0 falling, 1 rising
	localparam int STOP_BIT  = 3;   // 1 halts counting
	localparam int CTRL_W    = 4;   // implemented control bits

	typedef enum logic [1:0] {
		WIDE_TIMER,
		WIDE_PERIOD,
		WIDE_EVENT,
		WIDE_PULSE_HL
	} wide_mode_t;

	// ==========================================================
	// request flag positions
	localparam int FLAG_FIXED = 0;  // fixed timer underflow
	localparam int FLAG_WIDE  = 1;  // wide timer underflow
	localparam int FLAG_PIN   = 2;  // input pin edge
	localparam int FLAG_SEL   = 3;  // selectable timer underflow
	localparam int FLAG_W     = 4;

	// ==========================================================
	// count source codes for the selectable pair
	localparam logic [1:0] SRC_DIV16 = 2'h0;
	localparam logic [1:0] SRC_DIV8  = 2'h1;
	localparam logic [1:0] SRC_DIV2  = 2'h2;
	localparam logic [1:0] SRC_DIV1  = 2'h3;
	localparam int         SRC_W     = 2;

	// ==========================================================
	// oscillator divider and reset values
	localparam int          OSC_DIV        = 16;
	localparam int          DIV_W          = $clog2(OSC_DIV);
	localparam logic [7:0]  BYTE_RESET     = 8'hFF;
	localparam logic [15:0] WIDE_RESET     = 16'hFFFF;

endpackage : reload_timer_pkg

// ### verilog/timer_pair.sv
// prescaler feeding a timer, both down counting with reload latches
module timer_pair
	import reload_timer_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// count source and loads
	input  wire logic             tick,        // one count pulse
	input  wire logic             pre_load,    // write prescaler latch and counter
	input  wire logic             tmr_load,    // write timer latch and counter
	input  wire logic [WIDTH-1:0] load_value,
	// live counts and underflow
	output logic      [WIDTH-1:0] pre_count,
	output logic      [WIDTH-1:0] tmr_count,
	output logic                  underflow    // high one cycle per underflow
);

	// ==========================================================
	// elaboration check
	// reset value is one byte, so wider pairs cannot be reset cleanly
	if (WIDTH < 2 || WIDTH > 8) begin : g_bad_width
		$error("timer_pair width must be 2 to 8");
	end

	logic [WIDTH-1:0] pre_latch_reg;  // prescaler reload value
	logic [WIDTH-1:0] tmr_latch_reg;  // timer reload value
	logic             pre_uf;         // prescaler passes zero
	logic             tmr_uf;         // timer passes zero

	assign pre_uf = tick & (pre_count == '0);
	assign tmr_uf = pre_uf & (tmr_count == '0);

	// ==========================================================
	// prescaler: write loads both latch and counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_latch_reg <= BYTE_RESET[WIDTH-1:0];
			pre_count     <= BYTE_RESET[WIDTH-1:0];
		end else if (pre_load) begin
			pre_latch_reg <= load_value;
			pre_count     <= load_value;
		end else if (pre_uf) begin
			pre_count     <= pre_latch_reg;
		end else if (tick) begin
			pre_count     <= pre_count - 1'b1;
		end
	end

	// ==========================================================
	// timer: clocked by prescaler underflows
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tmr_latch_reg <= BYTE_RESET[WIDTH-1:0];
			tmr_count     <= BYTE_RESET[WIDTH-1:0];
		end else if (tmr_load) begin
			tmr_latch_reg <= load_value;
			tmr_count     <= load_value;
		end else if (tmr_uf) begin
			tmr_count     <= tmr_latch_reg;
		end else if (pre_uf) begin
			tmr_count     <= tmr_count - 1'b1;
		end
	end

	// ==========================================================
	// registered underflow pulse, rising on the same edge as the reload
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			underflow <= 1'b0;
		end else begin
			underflow <= tmr_uf;
		end
	end

endmodule // timer_pair

// ### tb/pin_source.sv
// far-side event source driving the wide timer input pin
module pin_source (
	// request from the bench
	input  wire logic level_req,
	// pin towards the timer unit
	output logic      pin
);
	timeunit 1ns;
	timeprecision 100ps;
	// asynchronous source: edges land off the clock grid on purpose
	initial pin = 1'b0;
	always @(level_req) pin <= #1.3 level_req;
endmodule // pin_source

// ### tb/reload_timer_monitor.sv
// bus handshake checker for the reload timer unit
module reload_timer_monitor
	import reload_timer_pkg::*;
(
	// clock and reset
	input wire logic              aclk,
	input wire logic              aresetn,
	// write channels
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	// read channels
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ==========================================================
	// write path: one write at a time, answer two edges after take
	busy_write_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer late or early");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped early");
	b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
		else $error("write answer not released");
	// ==========================================================
	// read path: registers are one byte wide, errors read as zero
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed while pending");
	r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read answer not released");
	byte_read_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("error read returned data");
endmodule // reload_timer_monitor
bind reload_timer_unit reload_timer_monitor mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ### tb/test_reload_timer_unit.sv
// self-checking bench for the reload timer unit
module test_reload_timer_unit
	import reload_timer_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// stimulus, bus and bookkeeping
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        level_req = 1'b0;
	logic        wide_timer_input_pin;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	int          error_cnt = 0;
	int          comparisons = 0;
	int          cyc = 0;
	logic [31:0] seed = 32'h000119AF;
	always #2.5 aclk = ~aclk;
	reload_timer_unit dut (.aclk, .aresetn, .wide_timer_input_pin, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	pin_source src (.level_req, .pin(wide_timer_input_pin));
	// ==========================================================
	// helpers and expectations
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// pulse mode flags both edges, else only the selected one
	function automatic logic pin_exp(int m, int e, int rise);
		return (m == 3) || (e == rise);
	endfunction
	// tick phase is unknown, so one count either way is allowed
	function automatic logic near(logic [15:0] a, int n);
		return (int'(a) - n) inside {-1, 0, 1};
	endfunction
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		comparisons++;
		if (e !== g) begin
			$display("[FAIL] %s expected %h seen %h", n, e, g);
			error_cnt++;
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		fork
			begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
			begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
		join
		do @(posedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic wv(logic [7:0] a, logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk("bresp", 32'(RESP_OKAY), 32'(r));
	endtask
	task automatic rv(logic [7:0] a, output logic [31:0] d);
		logic [1:0] r;
		rd(a, d, r);
		chk("rresp", 32'(RESP_OKAY), 32'(r));
	endtask
	task automatic wide_wr(logic [15:0] v);
		wv(OFS_WIDE_LOW, 32'(v[7:0]));
		wv(OFS_WIDE_HIGH, 32'(v[15:8]));
	endtask
	task automatic wide_rd(output logic [15:0] v);
		logic [31:0] h, l;
		rv(OFS_WIDE_HIGH, h);
		rv(OFS_WIDE_LOW, l);
		v = {h[7:0], l[7:0]};
	endtask
	task automatic pin_to(logic l);
		level_req <= l;
		repeat (8) @(posedge aclk);
	endtask
	task automatic done_t(string n);
		$display("test %s done", n);
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// hang guard, far above the few thousand cycles the run needs
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			finish_test();
		end
	end
	// ==========================================================
	// main sequence
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [15:0] v, w, w0;
		logic [7:0]  b;
		int          t, u;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		wr(8'h24, 32'h1, r);
		chk("bresp", 32'(RESP_SLVERR), 32'(r));
		rd(8'h24, d, r);
		chk("rresp", 32'(RESP_SLVERR), 32'(r));
		chk("rdata", 32'h0, d);
		// a write with the low lane disabled must leave the register alone
		s_axi_wstrb <= 4'hE;
		wv(OFS_WIDE_MODE, 32'h8);
		s_axi_wstrb <= 4'hF;
		rv(OFS_WIDE_MODE, d);
		chk("strobe off", 32'h0, d);
		done_t("unmapped");
		// fixed pair: load, then four timer steps of 64 cycles
		b = 8'(rnd()) | 8'h10;
		wv(OFS_FIXED_PRE, 32'h3);
		wv(OFS_FIXED_TMR, 32'(b));
		rv(OFS_FIXED_TMR, d);
		chk("fixed load", 32'(b), d);
		repeat (256) @(posedge aclk);
		rv(OFS_FIXED_TMR, d);
		chk("fixed rate", 32'h1, 32'(near(16'(b - d[7:0]), 4)));
		wv(OFS_FIXED_PRE, 32'h0);
		wv(OFS_FIXED_TMR, 32'h0);
		wv(OFS_FLAGS, 32'hF);
		repeat (40) @(posedge aclk);
		rv(OFS_FLAGS, d);
		chk("fixed flag", 32'h1, 32'(d[FLAG_FIXED]));
		done_t("fixed");
		// selectable pair over every count source
		for (int s = 0; s < 4; s++) begin
			wv(OFS_SEL_SRC, 32'(s));
			wv(OFS_SEL_PRE, 32'h0);
			wv(OFS_SEL_TMR, 32'hF0);
			repeat (64) @(posedge aclk);
			rv(OFS_SEL_TMR, d);
			t = 64 / (s == 0 ? 16 : s == 1 ? 8 : s == 2 ? 2 : 1);
			u = 240 - int'(d[7:0]);
			chk("sel rate", 32'h1, 32'(u >= t && u <= t + 8));
		end
		wv(OFS_SEL_TMR, 32'h0);
		wv(OFS_FLAGS, 32'hF);
		repeat (8) @(posedge aclk);
		rv(OFS_FLAGS, d);
		chk("sel flag", 32'h1, 32'(d[FLAG_SEL]));
		done_t("selectable");
		// wide timer: buffered low byte, stop, run rate
		v = 16'(rnd()) | 16'h0100;
		wv(OFS_WIDE_MODE, 32'h8);
		wide_rd(w0);
		wv(OFS_WIDE_LOW, 32'(v[7:0]));
		wide_rd(w);
		chk("low alone", 32'(w0), 32'(w));
		wv(OFS_WIDE_HIGH, 32'(v[15:8]));
		repeat (48) @(posedge aclk);
		wide_rd(w);
		chk("stopped", 32'(v), 32'(w));
		wv(OFS_WIDE_MODE, 32'h0);
		repeat (160) @(posedge aclk);
		wide_rd(w);
		chk("wide rate", 32'h1, 32'(near(v - w, 10)));
		// zero load underflows on every tick, so the wide flag must come up
		wide_wr(16'h0000);
		wv(OFS_FLAGS, 32'hF);
		repeat (40) @(posedge aclk);
		rv(OFS_FLAGS, d);
		chk("wide flag", 32'h1, 32'(d[FLAG_WIDE]));
		// event mode counts only the selected edge
		b = 8'(rnd()) & 8'h4;
		wv(OFS_WIDE_MODE, 32'(b) | 32'h2);
		wide_wr(v);
		pin_to(1'b1);
		wide_rd(w);
		chk("event rise", 32'(v - 16'(b[2])), 32'(w));
		pin_to(1'b0);
		wide_rd(w);
		chk("event fall", 32'(v - 16'h1), 32'(w));
		done_t("wide");
		// pin flag for every mode and edge choice
		for (int m = 0; m < 4; m++)
			for (int e = 0; e < 2; e++) begin
				wv(OFS_WIDE_MODE, 32'(m + 4 * e));
				for (int l = 1; l >= 0; l--) begin
					wv(OFS_FLAGS, 32'hF);
					pin_to(l[0]);
					rv(OFS_FLAGS, d);
					chk("pin flag", 32'(pin_exp(m, e, l)), 32'(d[FLAG_PIN]));
				end
			end
		// period capture: reload per edge, third edge refused while held
		wv(OFS_WIDE_MODE, 32'h5);
		wide_wr(v);
		t = cyc;
		pin_to(1'b1);
		wide_rd(w);
		pin_to(1'b0);
		repeat (300) @(posedge aclk);
		u = cyc;
		pin_to(1'b1);
		pin_to(1'b0);
		repeat (600) @(posedge aclk);
		pin_to(1'b1);
		wide_rd(w);
		chk("capture", 32'h1, 32'(near(v - w, (u - t) / 16)));
		done_t("capture");
		finish_test();
	end
endmodule // test_reload_timer_unit
